//--- design/flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"

module flag_bank (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // software write
    input wire logic wr_en,
    input wire logic wr_one_clears,
    input wire pin_change_pkg::port_t wr_data,
    // hardware set and implemented bits
    input wire pin_change_pkg::port_t set,
    input wire pin_change_pkg::port_t impl_mask,
    // flags
    output pin_change_pkg::port_t flags
);
    import pin_change_pkg::*;

    genvar i;
    generate
        for (i = 0; i < `PORT_WIDTH; i++) begin : g_bit
            logic kept;
            always_comb begin
                if (!wr_en) begin
                    kept = flags[i];
                end else if (wr_one_clears) begin
                    kept = flags[i] & ~wr_data[i];
                end else begin
                    kept = wr_data[i];
                end
            end
            // set wins over a clearing write
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= (kept | set[i]) & impl_mask[i];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

//--- design/pin_change_edge_detect.sv
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"

module pin_change_edge_detect #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register port
    input wire pin_change_pkg::addr_t addr,
    input wire pin_change_pkg::port_t wdata,
    input wire logic wr,
    input wire logic rd,
    output pin_change_pkg::port_t rdata,
    // pins
    input wire pin_change_pkg::port_t portb_pin,
    input wire pin_change_pkg::port_t portc_pin,
    // interrupt
    output logic shared_change_irq_flag,
    output logic irq
);
    import pin_change_pkg::*;

    function automatic logic hit(input addr_t a, input addr_t off);
        return a == off;
    endfunction

    // small variant drops port B and C7/C6
    localparam port_t PORTB_MASK = LARGE_VARIANT ? `PORTB_IMPL_MASK : `RESET_BYTE;
    localparam port_t PORTC_MASK = LARGE_VARIANT ? `PORTC_IMPL_MASK_LARGE
                                                 : `PORTC_IMPL_MASK_SMALL;

    port_t portb_rise_enable_reg;
    port_t portb_fall_enable_reg;
    port_t portc_rise_enable_reg;
    port_t portc_fall_enable_reg;
    port_t portb_change_flag;
    port_t portc_change_flag;
    status_t status_reg;
    status_t status_next;
    status_t mask_reg;
    status_t mask_next;
    port_t rdata_reg;
    port_t rdata_next;
    logic irq_reg;
    port_t b_rise;
    port_t b_fall;
    port_t c_rise;
    port_t c_fall;
    port_t b_set;
    port_t c_set;
    port_t b_rise_set;
    port_t b_fall_set;
    port_t c_rise_set;
    port_t c_fall_set;

    pin_edge_sense u_sense_b (
        .clock(clock),
        .rstn(rstn),
        .pins(portb_pin),
        .impl_mask(PORTB_MASK),
        .rise(b_rise),
        .fall(b_fall)
    );

    pin_edge_sense u_sense_c (
        .clock(clock),
        .rstn(rstn),
        .pins(portc_pin),
        .impl_mask(PORTC_MASK),
        .rise(c_rise),
        .fall(c_fall)
    );

    assign b_rise_set = b_rise & portb_rise_enable_reg;
    // falling edge gated by its enable
    assign b_fall_set = b_fall & portb_fall_enable_reg;
    assign c_rise_set = c_rise & portc_rise_enable_reg;
    assign c_fall_set = c_fall & portc_fall_enable_reg;
    assign b_set = b_rise_set | b_fall_set;
    assign c_set = c_rise_set | c_fall_set;

    // enable registers, unimplemented bits never stored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            portb_rise_enable_reg <= `RESET_BYTE;
            portb_fall_enable_reg <= `RESET_BYTE;
            portc_rise_enable_reg <= `RESET_BYTE;
            portc_fall_enable_reg <= `RESET_BYTE;
        end else if (wr) begin
            if (hit(addr, `OFF_PORTB_RISE_ENABLE)) begin
                portb_rise_enable_reg <= wdata & PORTB_MASK;
            end
            if (hit(addr, `OFF_PORTB_FALL_ENABLE)) begin
                portb_fall_enable_reg <= wdata & PORTB_MASK;
            end
            if (hit(addr, `OFF_PORTC_RISE_ENABLE)) begin
                portc_rise_enable_reg <= wdata & PORTC_MASK;
            end
            if (hit(addr, `OFF_PORTC_FALL_ENABLE)) begin
                portc_fall_enable_reg <= wdata & PORTC_MASK;
            end
        end
    end

    // change flags written as values, set by hardware
    flag_bank u_flags_b (
        .clock(clock),
        .rstn(rstn),
        .wr_en(wr && hit(addr, `OFF_PORTB_CHANGE_FLAG)),
        .wr_one_clears(1'b0),
        .wr_data(wdata),
        .set(b_set),
        .impl_mask(PORTB_MASK),
        .flags(portb_change_flag)
    );

    flag_bank u_flags_c (
        .clock(clock),
        .rstn(rstn),
        .wr_en(wr && hit(addr, `OFF_PORTC_CHANGE_FLAG)),
        .wr_one_clears(1'b0),
        .wr_data(wdata),
        .set(c_set),
        .impl_mask(PORTC_MASK),
        .flags(portc_change_flag)
    );

    // shared flag raised by any enabled edge; status is write-one-to-clear, set wins
    always_comb begin
        status_next = status_reg;
        if (wr && hit(addr, `OFF_IRQ_STATUS)) begin
            status_next = status_reg & ~wdata[`STS_WIDTH-1:0];
        end
        status_next[`STS_SHARED_BIT] = status_next[`STS_SHARED_BIT] | (|b_set) | (|c_set);
        status_next[`STS_PORTB_BIT] = status_next[`STS_PORTB_BIT] | (|b_set);
        status_next[`STS_PORTC_BIT] = status_next[`STS_PORTC_BIT] | (|c_set);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // mask decoded once so the mask and irq move on the same edge
    always_comb begin
        mask_next = mask_reg;
        if (wr && hit(addr, `OFF_IRQ_MASK)) begin
            mask_next = wdata[`STS_WIDTH-1:0] & `STS_IMPL_MASK;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= '0;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // registered from next state so irq tracks status in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & mask_next);
        end
    end

    // read mux, unimplemented bits come from masked storage as zero
    always_comb begin
        case (addr)
            `OFF_PORTB_RISE_ENABLE: rdata_next = portb_rise_enable_reg;
            `OFF_PORTB_FALL_ENABLE: rdata_next = portb_fall_enable_reg;
            `OFF_PORTB_CHANGE_FLAG: rdata_next = portb_change_flag;
            `OFF_PORTC_RISE_ENABLE: rdata_next = portc_rise_enable_reg;
            `OFF_PORTC_FALL_ENABLE: rdata_next = portc_fall_enable_reg;
            `OFF_PORTC_CHANGE_FLAG: rdata_next = portc_change_flag;
            `OFF_IRQ_STATUS: rdata_next = {5'h0, status_reg};
            `OFF_IRQ_MASK: rdata_next = {5'h0, mask_reg};
            default: rdata_next = `RESET_BYTE;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= `RESET_BYTE;
        end else if (rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= `RESET_BYTE;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign shared_change_irq_flag = status_reg[`STS_SHARED_BIT];

    a_portb_fall_flag: assert property (@(posedge clock) disable iff (!rstn)
        |b_fall_set |=> ((portb_change_flag & $past(b_fall_set)) == $past(b_fall_set)))
        else $error("port B falling edge did not set its flag");

    a_portb_rise_flag: assert property (@(posedge clock) disable iff (!rstn)
        |b_rise_set |=> ((portb_change_flag & $past(b_rise_set)) == $past(b_rise_set)))
        else $error("port B rising edge did not set its flag");

    a_flag_holds_set: assert property (@(posedge clock) disable iff (!rstn)
        (portc_change_flag[0] && !(wr && addr == `OFF_PORTC_CHANGE_FLAG))
        |=> portc_change_flag[0])
        else $error("port C flag dropped without a write");

    a_flag_write_clears: assert property (@(posedge clock) disable iff (!rstn)
        (wr && addr == `OFF_PORTC_CHANGE_FLAG && wdata == 8'h00 && c_set == 8'h00)
        |=> portc_change_flag == 8'h00)
        else $error("writing zero did not clear port C flags");

    a_portb_low_zero: assert property (@(posedge clock) disable iff (!rstn)
        (rd && (addr == `OFF_PORTB_FALL_ENABLE || addr == `OFF_PORTB_CHANGE_FLAG))
        ##1 1 |-> rdata[3:0] == 4'h0)
        else $error("port B low nibble read nonzero");

    a_portc_rise_flag: assert property (@(posedge clock) disable iff (!rstn)
        |c_rise_set |=> ((portc_change_flag & $past(c_rise_set)) == $past(c_rise_set)))
        else $error("port C rising edge did not set its flag");

    a_portc_fall_flag: assert property (@(posedge clock) disable iff (!rstn)
        |c_fall_set |=> ((portc_change_flag & $past(c_fall_set)) == $past(c_fall_set)))
        else $error("port C falling edge did not set its flag");

    a_shared_flag_set: assert property (@(posedge clock) disable iff (!rstn)
        (|b_set || |c_set) |=> shared_change_irq_flag ##0 status_reg[`STS_SHARED_BIT])
        else $error("shared change flag not raised");

    a_variant_absent: assert property (@(posedge clock) disable iff (!rstn)
        !LARGE_VARIANT |-> (portb_change_flag == 8'h00 && portc_change_flag[7:6] == 2'h0))
        else $error("absent pins hold a flag");

    a_single_edge_once: assert property (@(posedge clock) disable iff (!rstn)
        c_rise[0] |=> !c_rise[0])
        else $error("one transition gave two edge pulses");

    a_irq_follows_mask: assert property (@(posedge clock) disable iff (!rstn)
        irq == |(status_reg & mask_reg))
        else $error("interrupt output disagrees with masked status");

    a_portb_flag_holds: assert property (@(posedge clock) disable iff (!rstn)
        (|portb_change_flag && !(wr && addr == `OFF_PORTB_CHANGE_FLAG))
        |=> ((portb_change_flag & $past(portb_change_flag)) == $past(portb_change_flag)))
        else $error("port B flag dropped without a write");

    a_flag_write_value: assert property (@(posedge clock) disable iff (!rstn)
        (wr && addr == `OFF_PORTB_CHANGE_FLAG)
        |=> portb_change_flag == (($past(wdata) | $past(b_set)) & PORTB_MASK))
        else $error("port B flag write not stored with set winning");

    a_flag_read_back: assert property (@(posedge clock) disable iff (!rstn)
        (rd && addr == `OFF_PORTC_CHANGE_FLAG) |=> rdata == $past(portc_change_flag))
        else $error("port C flag read returned wrong data");

    a_portb_enable_low: assert property (@(posedge clock) disable iff (!rstn)
        (portb_rise_enable_reg[3:0] == 4'h0 && portb_fall_enable_reg[3:0] == 4'h0))
        else $error("port B enable holds a low bit");

    // a flag may only rise through an enabled edge or a software write
    a_no_stray_flag: assert property (@(posedge clock) disable iff (!rstn)
        !(wr && addr == `OFF_PORTC_CHANGE_FLAG)
        |=> (portc_change_flag & ~$past(portc_change_flag) & ~$past(c_set)) == 8'h00)
        else $error("port C flag set without an enabled edge");

    a_variant_enables: assert property (@(posedge clock) disable iff (!rstn)
        !LARGE_VARIANT |-> (portb_rise_enable_reg == 8'h00 && portb_fall_enable_reg == 8'h00
        && portc_rise_enable_reg[7:6] == 2'h0 && portc_fall_enable_reg[7:6] == 2'h0))
        else $error("absent pins hold an enable");

    a_status_write_clears: assert property (@(posedge clock) disable iff (!rstn)
        (wr && addr == `OFF_IRQ_STATUS && b_set == 8'h00 && c_set == 8'h00)
        |=> (status_reg & $past(wdata[`STS_WIDTH-1:0])) == 3'h0)
        else $error("status write of one did not clear");

    // read data idles at zero so a late sample never sees stale data
    a_rdata_idle_zero: assert property (@(posedge clock) disable iff (!rstn)
        !rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");

    c_portb_edge: cover property (@(posedge clock) disable iff (!rstn) |b_set);
    c_portc_edge: cover property (@(posedge clock) disable iff (!rstn) |c_set);
    c_set_beats_clear: cover property (@(posedge clock) disable iff (!rstn)
        (wr && addr == `OFF_PORTC_CHANGE_FLAG && |c_set));
    c_irq_raised: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
    c_flag_read: cover property (@(posedge clock) disable iff (!rstn)
        (rd && addr == `OFF_PORTC_CHANGE_FLAG && |portc_change_flag));
endmodule

`default_nettype wire

//--- design/pin_change_map.svh
// Behaviour
// - port B upper pins falling-edge enables
// - port B flag set on enabled edge
// - flag holds until software clears it
// - flags software writable, hardware set, reset zero
// - port B lower four bits read zero
// - port C eight rising-edge enables
// - port C eight falling-edge enables
// - any flag set raises shared change flag
// - port B and C7/C6 only on large variant
`ifndef PIN_CHANGE_MAP_SVH
`define PIN_CHANGE_MAP_SVH

`define PORT_WIDTH 8
`define ADDR_WIDTH 4

`define OFF_PORTB_RISE_ENABLE 4'h0
`define OFF_PORTB_FALL_ENABLE 4'h1
`define OFF_PORTB_CHANGE_FLAG 4'h2
`define OFF_PORTC_RISE_ENABLE 4'h3
`define OFF_PORTC_FALL_ENABLE 4'h4
`define OFF_PORTC_CHANGE_FLAG 4'h5
`define OFF_IRQ_STATUS 4'h6
`define OFF_IRQ_MASK 4'h7

`define RESET_BYTE 8'h00
`define PORTB_IMPL_MASK 8'hF0
`define PORTC_IMPL_MASK_LARGE 8'hFF
`define PORTC_IMPL_MASK_SMALL 8'h3F

`define STS_SHARED_BIT 0
`define STS_PORTB_BIT 1
`define STS_PORTC_BIT 2
`define STS_WIDTH 3
`define STS_IMPL_MASK 3'h7

`define SYNC_PRIME_CYCLES 2'h3

`endif

//--- design/pin_change_pkg.sv
`include "pin_change_map.svh"

package pin_change_pkg;
    typedef logic [`PORT_WIDTH-1:0] port_t;
    typedef logic [`ADDR_WIDTH-1:0] addr_t;
    typedef logic [`STS_WIDTH-1:0] status_t;
endpackage

//--- design/pin_edge_sense.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"

module pin_edge_sense (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // pins and implemented-bit mask
    input wire pin_change_pkg::port_t pins,
    input wire pin_change_pkg::port_t impl_mask,
    // one-cycle edge pulses
    output pin_change_pkg::port_t rise,
    output pin_change_pkg::port_t fall
);
    import pin_change_pkg::*;

    port_t meta_reg;
    port_t sync_reg;
    port_t prev_reg;
    logic [1:0] prime_reg;
    logic primed;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= `RESET_BYTE;
            sync_reg <= `RESET_BYTE;
            prev_reg <= `RESET_BYTE;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // no edges until the pipeline holds real samples, so a pin high at reset is no rise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prime_reg <= 2'h0;
        end else if (prime_reg != `SYNC_PRIME_CYCLES) begin
            prime_reg <= prime_reg + 2'h1;
        end
    end

    assign primed = (prime_reg == `SYNC_PRIME_CYCLES);

    assign rise = primed ? (sync_reg & ~prev_reg & impl_mask) : `RESET_BYTE;
    assign fall = primed ? (~sync_reg & prev_reg & impl_mask) : `RESET_BYTE;
endmodule

`default_nettype wire

//--- verif/gpio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_model (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // levels asked for by the bench
    input wire pin_change_pkg::port_t b_level,
    input wire pin_change_pkg::port_t c_level,
    // driven pins
    output pin_change_pkg::port_t portb_pin,
    output pin_change_pkg::port_t portc_pin
);
    import pin_change_pkg::*;

    // levels held for whole cycles
    // pins move only after an edge, so each level lasts at least one cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            portb_pin <= 8'h00;
            portc_pin <= 8'h00;
        end else begin
            portb_pin <= b_level;
            portc_pin <= c_level;
        end
    end
endmodule

`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_change_map.svh"

`define CHECK(act, exp) begin tests_run++; if ((act) !== (exp)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, act, exp); end end

module tb_top;
    import pin_change_pkg::*;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    addr_t addr = 4'h0;
    port_t wdata = 8'h00;
    port_t b_level = 8'h00;
    port_t c_level = 8'h00;
    port_t rdata;
    port_t rdata_s;
    port_t portb_pin;
    port_t portc_pin;
    logic shared_change_irq_flag;
    logic irq;
    int failures = 0;
    int tests_run = 0;

    always #25 clock = ~clock;

    gpio_pin_model u_pins (.clock(clock), .rstn(rstn), .b_level(b_level),
        .c_level(c_level), .portb_pin(portb_pin), .portc_pin(portc_pin));

    pin_change_edge_detect #(.LARGE_VARIANT(1'b1)) u_dut (.clock(clock), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .portb_pin(portb_pin), .portc_pin(portc_pin),
        .shared_change_irq_flag(shared_change_irq_flag), .irq(irq));

    // small package variant shares bus and pins; only its read data is watched
    pin_change_edge_detect #(.LARGE_VARIANT(1'b0)) u_small (.clock(clock), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_s),
        .portb_pin(portb_pin), .portc_pin(portc_pin),
        .shared_change_irq_flag(), .irq());

    task automatic wr_reg(input addr_t a, input port_t d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input addr_t a, input port_t e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHECK(rdata, e)
    endtask

    // flags land three cycles after the pins move; six leaves margin
    task automatic drive_pins(input port_t b, input port_t c);
        @(posedge clock);
        b_level <= b;
        c_level <= c;
        repeat (6) @(posedge clock);
        #1;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            rd_chk(addr_t'(i), 8'h00);
        end
        wr_reg(4'h8, 8'hFF);
        rd_chk(4'h8, 8'h00);
        wr_reg(`OFF_PORTB_FALL_ENABLE, 8'hFF);
        rd_chk(`OFF_PORTB_FALL_ENABLE, 8'hF0);
        `CHECK(rdata_s, 8'h00)
        wr_reg(`OFF_PORTC_RISE_ENABLE, 8'h81);
        rd_chk(`OFF_PORTC_RISE_ENABLE, 8'h81);
        `CHECK(rdata_s, 8'h01)
        wr_reg(`OFF_PORTC_FALL_ENABLE, 8'h42);
        rd_chk(`OFF_PORTC_FALL_ENABLE, 8'h42);
        wr_reg(`OFF_PORTB_RISE_ENABLE, 8'h2F);
        rd_chk(`OFF_PORTB_RISE_ENABLE, 8'h20);
        wr_reg(`OFF_PORTB_FALL_ENABLE, 8'h10);
        wr_reg(`OFF_IRQ_MASK, 8'h01);
        // rising edges on enabled and disabled pins alike
        drive_pins(8'h30, 8'hC3);
        `CHECK(shared_change_irq_flag, 1'b1)
        `CHECK(irq, 1'b1)
        rd_chk(`OFF_PORTC_CHANGE_FLAG, 8'h81);
        `CHECK(rdata_s, 8'h01)
        rd_chk(`OFF_PORTB_CHANGE_FLAG, 8'h20);
        // falling edges add to the flags already held
        drive_pins(8'h00, 8'h00);
        rd_chk(`OFF_PORTB_CHANGE_FLAG, 8'h30);
        rd_chk(`OFF_PORTC_CHANGE_FLAG, 8'hC3);
        `CHECK(rdata_s, 8'h03)
        wr_reg(`OFF_PORTC_CHANGE_FLAG, 8'h00);
        rd_chk(`OFF_PORTC_CHANGE_FLAG, 8'h00);
        wr_reg(`OFF_PORTB_CHANGE_FLAG, 8'h0F);
        rd_chk(`OFF_PORTB_CHANGE_FLAG, 8'h00);
        repeat (8) @(posedge clock);
        rd_chk(`OFF_PORTC_CHANGE_FLAG, 8'h00);
        wr_reg(`OFF_IRQ_STATUS, 8'h07);
        rd_chk(`OFF_IRQ_STATUS, 8'h00);
        `CHECK(irq, 1'b0)
        wr_reg(`OFF_IRQ_MASK, 8'h00);
        drive_pins(8'h00, 8'h01);
        `CHECK(shared_change_irq_flag, 1'b1)
        `CHECK(irq, 1'b0)
        rd_chk(`OFF_IRQ_STATUS, 8'h05);
        wr_reg(`OFF_IRQ_MASK, 8'h04);
        // irq follows the mask on the very edge that writes it
        #1;
        `CHECK(irq, 1'b1)
        repeat (2) @(posedge clock);
        #1;
        `CHECK(irq, 1'b1)
        // reset in mid-run clears flags and enables
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(`OFF_PORTC_CHANGE_FLAG, 8'h00);
        `CHECK(shared_change_irq_flag, 1'b0)
        rd_chk(`OFF_PORTC_RISE_ENABLE, 8'h00);
        print_verdict();
    end
endmodule

`default_nettype wire
